// [include/adc_ch1_aux_regs.svh]
// register offsets, field positions, reset values and timing counts for the channel 1 / aux conversion bank
`ifndef ADC_CH1_AUX_REGS_SVH
`define ADC_CH1_AUX_REGS_SVH
`define ADDR_CH1_INPUT_CONFIG   8'h50
`define ADDR_AUX_CONV_CONTROL   8'h51
`define ADDR_CH1_VOLUME         8'h52
`define RST_CH1_INPUT_CONFIG    8'h00
`define RST_AUX_CONV_CONTROL    8'h00
`define RST_CH1_VOLUME          8'hA1
`define VOL_MUTE_CODE           8'h00
`define VOL_UNITY_CODE          8'hA1
`define REF_LEVEL_TOP           2'b00
`define CMTOL_RAIL              2'b10
`define IMP_40K                 2'b10
`define AUX_ENABLE_BIT          7
`define AUX_MODE_HI             6
`define AUX_MODE_LO             5
`define AUX_START_BIT           4
`define AUX_STOP_BIT            3
`define AUX_DONE_BIT            2
`define AUX_CONV_TIME_NS        1000
`define CLK_PERIOD_NS           10
`define AUX_CONV_CYCLES         ((`AUX_CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [include/adc_ch1_aux_pkg.sv]
// types shared by the channel 1 / aux conversion register bank
package adc_ch1_aux_pkg;
    typedef enum logic [1:0] {
        SRC_DIFF    = 2'b00,
        SRC_SINGLE  = 2'b01,
        SRC_MUX_POS = 2'b10,
        SRC_MUX_NEG = 2'b11
    } input_source_t;
    typedef enum logic [1:0] {
        AUX_ONE_SINGLE = 2'b00,
        AUX_ONE_MULTI  = 2'b01,
        AUX_SEQ_SINGLE = 2'b10,
        AUX_SEQ_MULTI  = 2'b11
    } aux_mode_t;
    // channel 1 input configuration fields, msb first as stored
    typedef struct packed {
        input_source_t ch1InputSource;
        logic [1:0]    ch1InputImpedance;
        logic [1:0]    ch1CommonModeTolerance;
        logic          ch1FullScaleSelect;
        logic          ch1BandwidthSelect;
    } ch1_cfg_t;
    // host register access strobe
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// [logic/aux_conv_sequencer.sv]
// auxiliary conversion timing engine: one-shot and sequential runs
`default_nettype none
`include "adc_ch1_aux_regs.svh"
module aux_conv_sequencer #(
    parameter int CONV_CYCLES = `AUX_CONV_CYCLES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire logic                          enable,
    input  wire adc_ch1_aux_pkg::aux_mode_t    mode,
    input  wire logic                          startPulse,
    input  wire logic                          stopLevel,
    output logic                               busy,
    output logic                               convDone
);
    import adc_ch1_aux_pkg::*;
    localparam int CW = $clog2(CONV_CYCLES + 1);
    logic [CW-1:0] cnt_r;       // cycles left in the running conversion
    logic [CW-1:0] cnt_nxt;
    logic          busy_r;      // a conversion is under way
    logic          busy_nxt;
    logic          done_r;      // one-cycle end-of-conversion pulse
    logic          done_nxt;
    logic          seqMode;
    assign seqMode = mode[1];
    // next state: sequential modes re-arm until stopped, one-shot runs once
    always_comb
    begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (!enable)
        begin
            // logic only runs while enabled
            busy_nxt = 1'b0;
            cnt_nxt  = '0;
        end
        else if (!busy_r)
        begin
            if ((!seqMode && startPulse) || (seqMode && !stopLevel))
            begin
                busy_nxt = 1'b1;
                cnt_nxt  = CW'(CONV_CYCLES);
            end
        end
        else if (seqMode && stopLevel)
        begin
            // stop halts a sequence at once
            busy_nxt = 1'b0;
            cnt_nxt  = '0;
        end
        else if (cnt_r == CW'(1))
        begin
            done_nxt = 1'b1;
            if (seqMode)
            begin
                // a sequence re-arms at once, so busy never drops between conversions
                cnt_nxt = CW'(CONV_CYCLES);
            end
            else
            begin
                busy_nxt = 1'b0;
                cnt_nxt  = '0;
            end
        end
        else
        begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end
    // register only
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end
    assign busy     = busy_r;
    assign convDone = done_r;
endmodule
`default_nettype wire

// [logic/adc_channel1_and_aux_conversion_cfg.sv]
// channel 1 input, aux conversion control and channel 1 volume registers
`default_nettype none
`include "adc_ch1_aux_regs.svh"
// Functional notes
// - source field: diff, single, mux positive, mux negative
// - impedance field: 5k, 10k, 40k, reserved
// - coupling field sets common-mode tolerance
// - wide bandwidth only with 40k impedance
// - aux runs when enabled; four modes
// - single-channel aux uses source mux setting
// - writing start bit launches one conversion
// - stop bit halts sequential conversion
// - done flag reads one after one-shot
// - volume: 0 mute, 1 -80dB, 0.5dB steps
// - volume resets to unity code
// - reference field: top, lower, half, reserved
module adc_channel1_and_aux_conversion_cfg #(
    parameter int CONV_CYCLES = `AUX_CONV_CYCLES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          srst,
    input  wire adc_ch1_aux_pkg::reg_req_t     regReq,
    input  wire logic [1:0]                    referenceLevelSelect,
    output logic [7:0]                         regRdata,
    output adc_ch1_aux_pkg::ch1_cfg_t          ch1Cfg,
    output logic [7:0]                         ch1DigitalVolume,
    output logic                               ch1Mute,
    output logic                               ch1FullScaleEffective,
    output logic                               ch1WideBandEffective,
    output logic                               auxConvBusy,
    output logic                               auxSelectNegativePin,
    output logic                               auxMultiChannel
);
    import adc_ch1_aux_pkg::*;
    ch1_cfg_t   cfg_r;          // channel 1 input configuration
    ch1_cfg_t   cfg_nxt;
    logic       auxEnable_r;    // aux converter enable
    logic       auxEnable_nxt;
    aux_mode_t  auxMode_r;      // aux mode field
    aux_mode_t  auxMode_nxt;
    logic       auxStart_r;     // start bit as last written
    logic       auxStart_nxt;
    logic       auxStop_r;      // sequential stop level
    logic       auxStop_nxt;
    logic       auxDone_r;      // one-shot done status
    logic       auxDone_nxt;
    logic [7:0] vol_r;          // digital volume code
    logic [7:0] vol_nxt;
    logic [7:0] rdata_r;        // registered read data
    logic [7:0] rdata_nxt;
    logic       startPulse;     // one-cycle start toward the sequencer
    logic       convDone;
    logic       wrCfg;
    logic       wrAux;
    logic       wrVol;

    // address decode for writes
    always_comb
    begin
        wrCfg = 1'b0;
        wrAux = 1'b0;
        wrVol = 1'b0;
        if (regReq.wrEn && regReq.addr == `ADDR_CH1_INPUT_CONFIG)
            wrCfg = 1'b1;
        else if (regReq.wrEn && regReq.addr == `ADDR_AUX_CONV_CONTROL)
            wrAux = 1'b1;
        else if (regReq.wrEn && regReq.addr == `ADDR_CH1_VOLUME)
            wrVol = 1'b1;
    end

    // writing one to the start bit is the one-shot launch; sequential modes start without it while stop is clear
    assign startPulse = wrAux && regReq.wdata[`AUX_START_BIT];

    // next values of the writable fields and the done flag
    always_comb
    begin
        cfg_nxt       = cfg_r;
        auxEnable_nxt = auxEnable_r;
        auxMode_nxt   = auxMode_r;
        auxStart_nxt  = auxStart_r;
        auxStop_nxt   = auxStop_r;
        auxDone_nxt   = auxDone_r;
        vol_nxt       = vol_r;
        if (wrCfg)
            cfg_nxt = ch1_cfg_t'(regReq.wdata);
        if (wrAux)
        begin
            auxEnable_nxt = regReq.wdata[`AUX_ENABLE_BIT];
            auxMode_nxt   = aux_mode_t'(regReq.wdata[`AUX_MODE_HI:`AUX_MODE_LO]);
            auxStart_nxt  = regReq.wdata[`AUX_START_BIT];
            auxStop_nxt   = regReq.wdata[`AUX_STOP_BIT];
            // reserved low bits are not stored, so they always read zero
        end
        if (wrVol)
            vol_nxt = regReq.wdata;
        // a new start clears done; completion in the same cycle still wins
        if (startPulse)
            auxDone_nxt = 1'b0;
        if (convDone && !auxMode_r[1])
            auxDone_nxt = 1'b1;
    end

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (regReq.rdEn)
        begin
            if (regReq.addr == `ADDR_CH1_INPUT_CONFIG)
                rdata_nxt = cfg_r;
            else if (regReq.addr == `ADDR_AUX_CONV_CONTROL)
                rdata_nxt = {auxEnable_r, auxMode_r, auxStart_r, auxStop_r, auxDone_r, 2'b00};
            else if (regReq.addr == `ADDR_CH1_VOLUME)
                rdata_nxt = vol_r;
            else
                rdata_nxt = 8'h00;
        end
    end

    // register only
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            cfg_r       <= ch1_cfg_t'(`RST_CH1_INPUT_CONFIG);
            auxEnable_r <= 1'b0;
            auxMode_r   <= AUX_ONE_SINGLE;
            auxStart_r  <= 1'b0;
            auxStop_r   <= 1'b0;
            auxDone_r   <= 1'b0;
            vol_r       <= `RST_CH1_VOLUME;
            rdata_r     <= 8'h00;
        end
        else
        begin
            cfg_r       <= cfg_nxt;
            auxEnable_r <= auxEnable_nxt;
            auxMode_r   <= auxMode_nxt;
            auxStart_r  <= auxStart_nxt;
            auxStop_r   <= auxStop_nxt;
            auxDone_r   <= auxDone_nxt;
            vol_r       <= vol_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // conversion timing lives in its own engine
    // it sees the values this edge stores, so enable, mode and start written together act at once
    aux_conv_sequencer #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_seq (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .enable     (auxEnable_nxt),
        .mode       (auxMode_nxt),
        .startPulse (startPulse),
        .stopLevel  (auxStop_nxt),
        .busy       (auxConvBusy),
        .convDone   (convDone)
    );

    // outputs toward the analog chain
    assign regRdata         = rdata_r;
    assign ch1Cfg           = cfg_r;
    assign ch1DigitalVolume = vol_r;
    assign ch1Mute          = (vol_r == `VOL_MUTE_CODE);
    // double range only honoured with top reference, audio band, rail-to-rail; software must keep this anyway
    assign ch1FullScaleEffective = cfg_r.ch1FullScaleSelect && (referenceLevelSelect == `REF_LEVEL_TOP)
                                   && !cfg_r.ch1BandwidthSelect
                                   && (cfg_r.ch1CommonModeTolerance == `CMTOL_RAIL);
    // wide band only honoured with the 40k setting
    assign ch1WideBandEffective = cfg_r.ch1BandwidthSelect && (cfg_r.ch1InputImpedance == `IMP_40K);
    // single-channel aux takes its pin from the source mux setting
    assign auxSelectNegativePin = !auxMode_r[0] && (cfg_r.ch1InputSource == SRC_MUX_NEG);
    assign auxMultiChannel      = auxMode_r[0];

    // assertions
    // volume comes out of reset at the unity code
    property p_vol_reset;
        @(posedge ref_clk) srst |=> (vol_r == `VOL_UNITY_CODE);
    endproperty
    a_vol_reset: assert property (p_vol_reset) else $error("volume not unity after reset");

    // a start with no completion beside it leaves done low
    property p_done_clear;
        @(posedge ref_clk) disable iff (srst) (startPulse && !convDone) |=> !auxDone_r;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared by start");

    // the end of a one-shot run raises done
    property p_done_set;
        @(posedge ref_clk) disable iff (srst) (convDone && !auxMode_r[1]) |=> auxDone_r;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set after one-shot");

    // a start written into an enabled, idle one-shot setup launches at once
    sequence s_launch;
        startPulse && auxEnable_nxt && !auxConvBusy && !auxMode_nxt[1];
    endsequence
    property p_start_busy;
        @(posedge ref_clk) disable iff (srst) s_launch |=> auxConvBusy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not launch");

    // stop in a sequential mode drops busy on the next cycle
    sequence s_seq_stop;
        auxStop_nxt && auxMode_nxt[1];
    endsequence
    property p_stop;
        @(posedge ref_clk) disable iff (srst) s_seq_stop |=> !auxConvBusy;
    endproperty
    a_stop: assert property (p_stop) else $error("sequence kept running after stop");

    // a sequence left running keeps busy high across conversion boundaries
    sequence s_seq_running;
        auxConvBusy && auxEnable_nxt && auxMode_nxt[1] && !auxStop_nxt;
    endsequence
    property p_seq_runs;
        @(posedge ref_clk) disable iff (srst) s_seq_running |=> auxConvBusy;
    endproperty
    a_seq_runs: assert property (p_seq_runs) else $error("sequence paused between conversions");

    // clearing enable aborts any run on the next cycle
    property p_disabled;
        @(posedge ref_clk) disable iff (srst) !auxEnable_nxt |=> !auxConvBusy;
    endproperty
    a_disabled: assert property (p_disabled) else $error("aux busy while disabled");

    // busy is only ever seen with the enable bit stored
    property p_busy_enabled;
        @(posedge ref_clk) disable iff (srst) auxConvBusy |-> auxEnable_r;
    endproperty
    a_busy_enabled: assert property (p_busy_enabled) else $error("aux busy with enable clear");

    // mute follows the zero code both ways
    property p_mute;
        @(posedge ref_clk) disable iff (srst) ch1Mute == (ch1DigitalVolume == `VOL_MUTE_CODE);
    endproperty
    a_mute: assert property (p_mute) else $error("mute and volume code disagree");

    // a volume write shows on the output the next cycle
    property p_vol_wr;
        @(posedge ref_clk) disable iff (srst) wrVol |=> (ch1DigitalVolume == $past(regReq.wdata));
    endproperty
    a_vol_wr: assert property (p_vol_wr) else $error("volume write lost");

    // wide band is never passed on without the 40k setting
    property p_wide;
        @(posedge ref_clk) disable iff (srst) ch1WideBandEffective |-> (cfg_r.ch1InputImpedance == `IMP_40K);
    endproperty
    a_wide: assert property (p_wide) else $error("wide band without 40k");

    // any reference below the top one takes the double range away
    property p_ref_gate;
        @(posedge ref_clk) disable iff (srst) (referenceLevelSelect != `REF_LEVEL_TOP) |-> !ch1FullScaleEffective;
    endproperty
    a_ref_gate: assert property (p_ref_gate) else $error("double range with low reference");

    // the double range also needs rail-to-rail tolerance
    property p_cmtol_gate;
        @(posedge ref_clk) disable iff (srst) (cfg_r.ch1CommonModeTolerance != `CMTOL_RAIL) |-> !ch1FullScaleEffective;
    endproperty
    a_cmtol_gate: assert property (p_cmtol_gate) else $error("double range without rail-to-rail");

    // and the select bit with audio bandwidth
    property p_full_scale_gate;
        @(posedge ref_clk) disable iff (srst)
            ch1FullScaleEffective |-> (cfg_r.ch1FullScaleSelect && !cfg_r.ch1BandwidthSelect);
    endproperty
    a_full_scale_gate: assert property (p_full_scale_gate) else $error("double range in wide band");

    // the negative mux pin only serves single-channel modes with source three
    property p_neg_pin;
        @(posedge ref_clk) disable iff (srst)
            auxSelectNegativePin |-> (!auxMultiChannel && cfg_r.ch1InputSource == SRC_MUX_NEG);
    endproperty
    a_neg_pin: assert property (p_neg_pin) else $error("negative pin picked wrongly");

    // an input config write lands the next cycle
    property p_cfg_wr;
        @(posedge ref_clk) disable iff (srst) wrCfg |=> (ch1Cfg == $past(regReq.wdata));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("input config write lost");

    // a config read returns the stored fields
    property p_cfg_rd;
        @(posedge ref_clk) disable iff (srst)
            (regReq.rdEn && regReq.addr == `ADDR_CH1_INPUT_CONFIG) |=> (regRdata == $past(cfg_r));
    endproperty
    a_cfg_rd: assert property (p_cfg_rd) else $error("input config read wrong");

    // the reserved low bits of the aux register always read zero
    property p_aux_rsvd;
        @(posedge ref_clk) disable iff (srst)
            (regReq.rdEn && regReq.addr == `ADDR_AUX_CONV_CONTROL) |=> (regRdata[1:0] == 2'b00);
    endproperty
    a_aux_rsvd: assert property (p_aux_rsvd) else $error("reserved aux bits read nonzero");

    // offsets outside the bank read zero
    sequence s_unmapped_rd;
        regReq.rdEn && regReq.addr != `ADDR_CH1_INPUT_CONFIG
        && regReq.addr != `ADDR_AUX_CONV_CONTROL && regReq.addr != `ADDR_CH1_VOLUME;
    endsequence
    property p_unmapped_rd;
        @(posedge ref_clk) disable iff (srst) s_unmapped_rd |=> (regRdata == 8'h00);
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read nonzero");

    // read data stands until the next read
    property p_rdata_hold;
        @(posedge ref_clk) disable iff (srst) !regReq.rdEn |=> $stable(regRdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the channel 1 / aux conversion register bank
`default_nettype none
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ch1_aux_pkg::*;
    localparam int CONV = 4;        // short conversion keeps the run brief
    logic          ref_clk;         // 100 MHz register clock
    logic          srst;            // synchronous reset, active high
    reg_req_t      regReq;          // host access strobe
    logic [1:0]    refSel;          // reference level from outside the bank
    logic [7:0]    regRdata;        // read data
    ch1_cfg_t      ch1Cfg;          // decoded channel configuration
    logic [7:0]    ch1DigitalVolume;
    logic          ch1Mute;
    logic          fullScaleEff;
    logic          wideBandEff;
    logic          auxConvBusy;
    logic          auxSelNeg;
    logic          auxMulti;
    int            errors;          // mismatches seen
    int            nCompared;       // comparisons made
    int            cyc;             // cycles since start, for the hang guard
    logic [7:0]    d;               // scratch read value
    adc_channel1_and_aux_conversion_cfg #(.CONV_CYCLES(CONV)) dut (
        .ref_clk(ref_clk), .srst(srst), .regReq(regReq), .referenceLevelSelect(refSel),
        .regRdata(regRdata), .ch1Cfg(ch1Cfg), .ch1DigitalVolume(ch1DigitalVolume), .ch1Mute(ch1Mute),
        .ch1FullScaleEffective(fullScaleEff), .ch1WideBandEffective(wideBandEff),
        .auxConvBusy(auxConvBusy), .auxSelectNegativePin(auxSelNeg), .auxMultiChannel(auxMulti));
    // free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // strobes go up at an edge and drop after the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: v};
        @(posedge ref_clk);
        regReq <= '0;
        #1;
    endtask
    // read data is registered on the taking edge, so sample just after it
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        regReq <= '0;
        #1 v = regRdata;
    endtask
    // bounded wait for the converter to go idle
    task automatic waitIdle();
        for (int i = 0; i < 4 * CONV && auxConvBusy !== 1'b0; i++)
            @(posedge ref_clk) #1;
        `CHK(auxConvBusy, 1'b0)
    endtask
    task automatic testReset();
        rd(8'h50, d);
        `CHK(d, 8'h00)
        rd(8'h51, d);
        `CHK(d, 8'h00)
        rd(8'h52, d);
        `CHK(d, 8'hA1)
        `CHK(ch1DigitalVolume, 8'hA1)
        rd(8'h53, d);
        `CHK(d, 8'h00)
        // reserved low bits written as zero; the other fields read back
        wr(8'h51, 8'h68);
        rd(8'h51, d);
        `CHK(d, 8'h68)
        $display("test reset done");
    endtask
    task automatic testConfig();
        for (int s = 0; s < 4; s++)
        begin
            // legal double range: rail-to-rail, audio band, top reference
            wr(8'h50, {s[1:0], 6'b01_10_10});
            `CHK(ch1Cfg, {s[1:0], 6'b01_10_10})
            rd(8'h50, d);
            `CHK(d, {s[1:0], 6'b01_10_10})
            `CHK(fullScaleEff, 1'b1)
        end
        // a lower reference takes the double range away
        @(posedge ref_clk);
        refSel <= 2'b01;
        #1;
        `CHK(fullScaleEff, 1'b0)
        @(posedge ref_clk);
        refSel <= 2'b00;
        #1;
        `CHK(fullScaleEff, 1'b1)
        wr(8'h50, 8'h56);
        `CHK(fullScaleEff, 1'b0)
        wr(8'h50, 8'h21);
        `CHK(wideBandEff, 1'b1)
        wr(8'h50, 8'h11);
        `CHK(wideBandEff, 1'b0)
        $display("test config done");
    endtask
    task automatic testVolume();
        wr(8'h52, 8'h00);
        `CHK(ch1Mute, 1'b1)
        wr(8'h52, 8'h01);
        `CHK(ch1Mute, 1'b0)
        wr(8'h52, 8'hFF);
        rd(8'h52, d);
        `CHK(d, 8'hFF)
        `CHK(ch1DigitalVolume, 8'hFF)
        $display("test volume done");
    endtask
    task automatic testModes();
        for (int s = 2; s < 4; s++)
        begin
            wr(8'h50, {s[1:0], 6'h00});
            for (int m = 0; m < 4; m++)
            begin
                wr(8'h51, {1'b0, m[1:0], 5'h00});
                `CHK(auxMulti, m[0])
                `CHK(auxSelNeg, (!m[0] && s == 3))
            end
        end
        // start while disabled launches nothing
        wr(8'h51, 8'h10);
        `CHK(auxConvBusy, 1'b0)
        rd(8'h51, d);
        `CHK(d, 8'h10)
        $display("test modes done");
    endtask
    task automatic testOneShot();
        // enable and start written together launch at once
        wr(8'h51, 8'h90);
        `CHK(auxConvBusy, 1'b1)
        rd(8'h51, d);
        `CHK(d, 8'h90)
        waitIdle();
        rd(8'h51, d);
        `CHK(d, 8'h94)
        // a fresh start hides the old completion
        wr(8'h51, 8'h90);
        rd(8'h51, d);
        `CHK(d, 8'h90)
        waitIdle();
        rd(8'h51, d);
        `CHK(d, 8'h94)
        // no start bit, no conversion
        wr(8'h51, 8'h80);
        `CHK(auxConvBusy, 1'b0)
        // disabling mid-run aborts without completion
        wr(8'h51, 8'h90);
        wr(8'h51, 8'h00);
        `CHK(auxConvBusy, 1'b0)
        rd(8'h51, d);
        `CHK(d, 8'h00)
        $display("test one-shot done");
    endtask
    task automatic testSequence();
        wr(8'h50, 8'hC0);
        wr(8'h51, 8'hD0);
        `CHK(auxConvBusy, 1'b1)
        // several conversion boundaries pass with busy held
        repeat (3 * CONV) @(posedge ref_clk);
        #1;
        `CHK(auxConvBusy, 1'b1)
        wr(8'h51, 8'hC8);
        `CHK(auxConvBusy, 1'b0)
        // sequential runs never raise done
        rd(8'h51, d);
        `CHK(d, 8'hC8)
        $display("test sequence done");
    endtask
    // a reset in mid-run stops the engine and restores the volume and aux control fields
    task automatic testMidReset();
        wr(8'h52, 8'h40);
        wr(8'h51, 8'hD0);
        `CHK(auxConvBusy, 1'b1)
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        `CHK(auxConvBusy, 1'b0)
        `CHK(ch1DigitalVolume, 8'hA1)
        rd(8'h51, d);
        `CHK(d, 8'h00)
        $display("test mid-run reset done");
    endtask
    task automatic finishTest();
        $display("compared %0d, mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            finishTest();
        end
    end
    // main sequence
    initial
    begin
        errors = 0;
        nCompared = 0;
        cyc = 0;
        regReq = '0;
        refSel = 2'b00;
        srst = 1'b1;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        testReset();
        testConfig();
        testVolume();
        testModes();
        testOneShot();
        testSequence();
        testMidReset();
        finishTest();
    end
endmodule
`default_nettype wire
